// File: shared/bsp_defs.svh
// How it works
// - Supply arrival starts comparators and switch driver, resets registers, readies the bus.
// - After power-on reset the host may write the disable, watchdog period and boost select registers.
// - Battery alone and above depletion level closes the battery switch.
// - Battery-only operation keeps the internal bias regulator off.
// - Overload opens the switch at once until an input source returns.
// - The battery switch disable bit forces the switch open.
// - An open switch gives no charge and no discharge path.
// - Plugging in an adapter closes a disabled switch again.
// - Boost current select picks boost current and blocking-switch threshold.
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH

// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define BSP_WDT_W 2
`define BSP_WDT_OFF 2'h0
`define BSP_WDT_RST 2'h1
`define BSP_DISABLE_RST 1'h0
`define BSP_BOOST_RST 1'h0
`define BSP_SYNC_W 4
`define BSP_SYNC_VBUS 0
`define BSP_SYNC_BAT 1
`define BSP_SYNC_DEPL 2
`define BSP_SYNC_OVLD 3

`endif

// File: shared/bsp_pkg.sv
// ****************************************************************
// Types
// ****************************************************************
package bsp_pkg;
  typedef enum logic [1:0] {
    BSP_POWER_OFF,
    BSP_POR_RESET,
    BSP_RUN
  } bsp_state_t;
endpackage : bsp_pkg

// File: rtl/bsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
// ****************************************************************
// Two-stage synchroniser, one pair per bit
// ****************************************************************
module bsp_sync
  import bsp_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [`BSP_SYNC_W-1:0] async_in,
  output logic [`BSP_SYNC_W-1:0] sync_out
);
  logic [`BSP_SYNC_W-1:0] stage1;
  logic [`BSP_SYNC_W-1:0] next_stage1;
  logic [`BSP_SYNC_W-1:0] next_sync;

  genvar i;
  generate
    for (i = 0; i < `BSP_SYNC_W; i = i + 1) begin : g_bit
      always_comb begin
        next_stage1[i] = srst_in ? 1'h0 : async_in[i];
        next_sync[i] = srst_in ? 1'h0 : stage1[i];
      end
      always_ff @(posedge clock_in) begin
        stage1[i] <= next_stage1[i];
        sync_out[i] <= next_sync[i];
      end
    end
  endgenerate
endmodule : bsp_sync
`default_nettype wire

// File: rtl/bsp_power_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
module bsp_power_seq
  import bsp_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic vbus_present_in,
  input wire logic battery_present_in,
  input wire logic battery_above_depletion_in,
  input wire logic overload_in,
  input wire logic watchdog_expired_in,
  input wire logic cfg_write_in,
  input wire logic cfg_disable_in,
  input wire logic [`BSP_WDT_W-1:0] cfg_wdt_period_in,
  input wire logic cfg_boost_sel_in,
  output logic comparators_enable_out,
  output logic reg_reset_out,
  output logic serial_ready_out,
  output logic battery_switch_on_out,
  output logic bias_regulator_on_out,
  output logic charge_path_enable_out,
  output logic discharge_path_enable_out,
  output logic battery_switch_disable_out,
  output logic [`BSP_WDT_W-1:0] watchdog_period_out,
  output logic boost_current_high_out,
  output logic rb_ocp_high_out,
  output logic overload_latched_out
);
  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [`BSP_SYNC_W-1:0] sync;
  logic vbus_s;
  logic bat_s;
  logic depl_s;
  logic ovld_s;

  bsp_sync u_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in({overload_in, battery_above_depletion_in,
               battery_present_in, vbus_present_in}),
    .sync_out(sync)
  );

  assign vbus_s = sync[`BSP_SYNC_VBUS];
  assign bat_s = sync[`BSP_SYNC_BAT];
  assign depl_s = sync[`BSP_SYNC_DEPL];
  assign ovld_s = sync[`BSP_SYNC_OVLD];

  // ****************************************************************
  // Sequencer and control state
  // ****************************************************************
  bsp_state_t state;
  bsp_state_t next_state;
  logic vbus_prev;
  logic next_vbus_prev;
  logic power_ok;
  logic por_start;
  logic running;
  logic adapter_plug;
  logic wdt_restore;
  logic host_write;
  logic next_comparators;
  logic next_reg_reset;
  logic next_serial_ready;
  logic next_switch_on;
  logic next_bias_on;
  logic next_charge_path;
  logic next_discharge_path;
  logic next_disable;
  logic [`BSP_WDT_W-1:0] next_wdt;
  logic next_boost;
  logic next_overload;

  always_comb begin
    power_ok = vbus_s | bat_s;
    por_start = (state == BSP_POWER_OFF) && power_ok;
    running = (state == BSP_RUN);
    adapter_plug = running && vbus_s && !vbus_prev;
    wdt_restore = running && watchdog_expired_in &&
                  (watchdog_period_out != `BSP_WDT_OFF);
    host_write = running && cfg_write_in;
    next_vbus_prev = srst_in ? 1'h0 : vbus_s;

    next_state = state;
    unique case (state)
      BSP_POWER_OFF: begin
        if (power_ok) begin
          next_state = BSP_POR_RESET;
        end
      end
      BSP_POR_RESET: begin
        next_state = power_ok ? BSP_RUN : BSP_POWER_OFF;
      end
      BSP_RUN: begin
        if (!power_ok) begin
          next_state = BSP_POWER_OFF;
        end
      end
    endcase
    if (srst_in) begin
      next_state = BSP_POWER_OFF;
    end

    next_disable = battery_switch_disable_out;
    next_wdt = watchdog_period_out;
    next_boost = boost_current_high_out;
    if (srst_in || por_start || wdt_restore) begin
      next_disable = `BSP_DISABLE_RST;
      next_wdt = `BSP_WDT_RST;
      next_boost = `BSP_BOOST_RST;
    end else begin
      if (adapter_plug) begin
        next_disable = 1'h0;
      end
      if (host_write) begin
        // Shipping mode is a single write of wdt off with disable set
        next_disable = cfg_disable_in;
        next_wdt = cfg_wdt_period_in;
        next_boost = cfg_boost_sel_in;
      end
    end

    next_overload = overload_latched_out;
    if (srst_in || por_start) begin
      next_overload = 1'h0;
    end else begin
      if (adapter_plug) begin
        next_overload = 1'h0;
      end
      if (running && ovld_s) begin
        next_overload = 1'h1;
      end
    end

    next_comparators = !srst_in && (next_state != BSP_POWER_OFF);
    next_reg_reset = !srst_in && por_start;
    next_serial_ready = !srst_in && (next_state == BSP_RUN);
    next_switch_on = !srst_in && (next_state == BSP_RUN) &&
                     !next_disable && !next_overload &&
                     (vbus_s || (bat_s && depl_s));
    next_bias_on = !srst_in && (next_state == BSP_RUN) && vbus_s;
    next_charge_path = next_switch_on && vbus_s;
    next_discharge_path = next_switch_on;
  end

  always_ff @(posedge clock_in) begin
    state <= next_state;
    vbus_prev <= next_vbus_prev;
    comparators_enable_out <= next_comparators;
    reg_reset_out <= next_reg_reset;
    serial_ready_out <= next_serial_ready;
    battery_switch_on_out <= next_switch_on;
    bias_regulator_on_out <= next_bias_on;
    charge_path_enable_out <= next_charge_path;
    discharge_path_enable_out <= next_discharge_path;
    battery_switch_disable_out <= next_disable;
    watchdog_period_out <= next_wdt;
    boost_current_high_out <= next_boost;
    rb_ocp_high_out <= next_boost;
    overload_latched_out <= next_overload;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  sequence s_power_arrives;
    (state == BSP_POWER_OFF) && power_ok;
  endsequence

  sequence s_por_then_ready;
    reg_reset_out && comparators_enable_out && !serial_ready_out
      ##1 serial_ready_out;
  endsequence

  a_por_sequence: assert property (
    s_power_arrives ##1 power_ok |-> s_por_then_ready)
    else $error("power-on reset sequence wrong");

  a_por_defaults: assert property (
    reg_reset_out |-> !battery_switch_disable_out && !boost_current_high_out
      && (watchdog_period_out == `BSP_WDT_RST))
    else $error("registers not at defaults after reset");

  a_battery_close: assert property (
    running && !vbus_s && bat_s && depl_s && !ovld_s &&
    !overload_latched_out && !battery_switch_disable_out && !cfg_write_in
    |=> battery_switch_on_out)
    else $error("battery switch did not close on battery");

  a_bias_battery: assert property (
    !vbus_s |=> !bias_regulator_on_out)
    else $error("bias regulator on from battery alone");

  a_overload_open: assert property (
    running && ovld_s |=> !battery_switch_on_out && overload_latched_out)
    else $error("switch not opened on overload");

  a_overload_hold: assert property (
    overload_latched_out && !adapter_plug |=> !battery_switch_on_out)
    else $error("switch closed before source returned");

  a_disable_open: assert property (
    battery_switch_disable_out |-> !battery_switch_on_out)
    else $error("disable bit did not open switch");

  a_no_path: assert property (
    !battery_switch_on_out |-> !charge_path_enable_out &&
      !discharge_path_enable_out)
    else $error("battery path present with switch open");

  a_ship_keep: assert property (
    running && power_ok && battery_switch_disable_out &&
    (watchdog_period_out == `BSP_WDT_OFF) && !vbus_s && !cfg_write_in
    |=> battery_switch_disable_out)
    else $error("shipping mode lost");

  a_adapter_close: assert property (
    adapter_plug && !cfg_write_in && !wdt_restore
    |=> !battery_switch_disable_out)
    else $error("adapter did not clear disable");

  a_boost_scale: assert property (
    $past(host_write) && !$past(wdt_restore) && !$past(srst_in) |->
      boost_current_high_out == $past(cfg_boost_sel_in) &&
      rb_ocp_high_out == boost_current_high_out)
    else $error("boost current select not applied");

  a_wdt_restore: assert property (
    wdt_restore |=> !battery_switch_disable_out &&
      (watchdog_period_out == `BSP_WDT_RST))
    else $error("watchdog expiry did not restore defaults");
endmodule : bsp_power_seq
`default_nettype wire

// File: testbench/bsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
// ****************************************************************
// Host side of the configuration writes
// ****************************************************************
module bsp_host_model
  import bsp_pkg::*;
(
  input wire logic clock_in,
  input wire logic serial_ready_in,
  output logic cfg_write_out,
  output logic cfg_disable_out,
  output logic [`BSP_WDT_W-1:0] cfg_wdt_period_out,
  output logic cfg_boost_sel_out
);
  initial begin
    cfg_write_out = 1'b0;
    cfg_disable_out = 1'b0;
    cfg_wdt_period_out = 2'h0;
    cfg_boost_sel_out = 1'b0;
  end

  task automatic write_cfg(input logic dis, input logic [1:0] wdt,
                           input logic bst);
    int i;
    i = 0;
    // Wait up to 16 cycles for the device to finish power-on reset, then talk anyway
    while (serial_ready_in !== 1'b1 && i < 16) begin
      @(negedge clock_in);
      i++;
    end
    @(negedge clock_in);
    cfg_write_out = 1'b1;
    cfg_disable_out = dis;
    cfg_wdt_period_out = wdt;
    cfg_boost_sel_out = bst;
    @(negedge clock_in);
    cfg_write_out = 1'b0;
    // Released fields no longer hold the written value
    cfg_disable_out = ~dis;
    cfg_wdt_period_out = ~wdt;
    cfg_boost_sel_out = ~bst;
  endtask : write_cfg
endmodule : bsp_host_model
`default_nettype wire

// File: testbench/tb_battery_switch_power_up.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end end
// ****************************************************************
// Testbench top
// ****************************************************************
module tb_battery_switch_power_up
  import bsp_pkg::*;
;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic vbus = 1'b0, bat = 1'b0, depl = 1'b0, ovld = 1'b0, wdx = 1'b0;
  logic wr, dis_w, bst_w;
  logic [`BSP_WDT_W-1:0] wdt_w, wdt;
  logic cmp_en, reg_rst, ser_rdy, sw, bias, chg, dchg, dis, bst, rb, lat;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #2 clock_in = ~clock_in;

  bsp_host_model host (.clock_in(clock_in), .serial_ready_in(ser_rdy),
    .cfg_write_out(wr), .cfg_disable_out(dis_w),
    .cfg_wdt_period_out(wdt_w), .cfg_boost_sel_out(bst_w));

  bsp_power_seq dut (.clock_in(clock_in), .srst_in(srst_in),
    .vbus_present_in(vbus), .battery_present_in(bat),
    .battery_above_depletion_in(depl), .overload_in(ovld),
    .watchdog_expired_in(wdx), .cfg_write_in(wr), .cfg_disable_in(dis_w),
    .cfg_wdt_period_in(wdt_w), .cfg_boost_sel_in(bst_w),
    .comparators_enable_out(cmp_en), .reg_reset_out(reg_rst),
    .serial_ready_out(ser_rdy), .battery_switch_on_out(sw),
    .bias_regulator_on_out(bias), .charge_path_enable_out(chg),
    .discharge_path_enable_out(dchg), .battery_switch_disable_out(dis),
    .watchdog_period_out(wdt), .boost_current_high_out(bst),
    .rb_ocp_high_out(rb), .overload_latched_out(lat));

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc

  task automatic wd_pulse();
    @(negedge clock_in);
    wdx = 1'b1;
    @(negedge clock_in);
    wdx = 1'b0;
    cyc(1);
  endtask : wd_pulse

  task automatic test_reset();
    cyc(5);
    `CHK("wdt", `BSP_WDT_RST, wdt)
    `CHK("sw", 1'b0, sw)
    `CHK("ready", 1'b0, ser_rdy)
    srst_in = 1'b0;
    $display("test reset done");
  endtask : test_reset

  task automatic test_power_up();
    int i;
    bat = 1'b1;
    depl = 1'b1;
    i = 0;
    while (reg_rst !== 1'b1 && i < 8) begin
      cyc(1);
      i++;
    end
    `CHK("reg_reset", 1'b1, reg_rst)
    `CHK("cmp", 1'b1, cmp_en)
    cyc(1);
    `CHK("reg_reset", 1'b0, reg_rst)
    `CHK("ready", 1'b1, ser_rdy)
    `CHK("sw", 1'b1, sw)
    `CHK("dchg", 1'b1, dchg)
    `CHK("chg", 1'b0, chg)
    `CHK("bias", 1'b0, bias)
    $display("test power up done");
  endtask : test_power_up

  task automatic test_shipping();
    host.write_cfg(1'b1, `BSP_WDT_OFF, 1'b0);
    cyc(1);
    `CHK("dis", 1'b1, dis)
    `CHK("wdt", `BSP_WDT_OFF, wdt)
    `CHK("sw", 1'b0, sw)
    `CHK("dchg", 1'b0, dchg)
    wd_pulse();
    `CHK("dis", 1'b1, dis)
    vbus = 1'b1;
    cyc(5);
    `CHK("dis", 1'b0, dis)
    `CHK("sw", 1'b1, sw)
    `CHK("chg", 1'b1, chg)
    `CHK("bias", 1'b1, bias)
    $display("test shipping done");
  endtask : test_shipping

  task automatic test_boost();
    host.write_cfg(1'b0, 2'h2, 1'b1);
    cyc(1);
    `CHK("boost", 1'b1, bst)
    `CHK("rb", 1'b1, rb)
    host.write_cfg(1'b0, 2'h2, 1'b0);
    cyc(1);
    `CHK("boost", 1'b0, bst)
    `CHK("rb", 1'b0, rb)
    $display("test boost done");
  endtask : test_boost

  task automatic test_watchdog();
    host.write_cfg(1'b1, 2'h3, 1'b1);
    cyc(1);
    `CHK("sw", 1'b0, sw)
    wd_pulse();
    `CHK("dis", `BSP_DISABLE_RST, dis)
    `CHK("wdt", `BSP_WDT_RST, wdt)
    `CHK("boost", `BSP_BOOST_RST, bst)
    `CHK("sw", 1'b1, sw)
    $display("test watchdog done");
  endtask : test_watchdog

  task automatic test_overload();
    vbus = 1'b0;
    cyc(4);
    `CHK("bias", 1'b0, bias)
    `CHK("sw", 1'b1, sw)
    ovld = 1'b1;
    cyc(4);
    `CHK("sw", 1'b0, sw)
    `CHK("latch", 1'b1, lat)
    `CHK("dchg", 1'b0, dchg)
    ovld = 1'b0;
    cyc(6);
    `CHK("sw", 1'b0, sw)
    vbus = 1'b1;
    cyc(5);
    `CHK("latch", 1'b0, lat)
    `CHK("sw", 1'b1, sw)
    $display("test overload done");
  endtask : test_overload

  task automatic test_power_cycle();
    host.write_cfg(1'b1, 2'h3, 1'b1);
    vbus = 1'b0;
    bat = 1'b0;
    cyc(6);
    `CHK("cmp", 1'b0, cmp_en)
    `CHK("ready", 1'b0, ser_rdy)
    `CHK("sw", 1'b0, sw)
    bat = 1'b1;
    cyc(6);
    `CHK("dis", `BSP_DISABLE_RST, dis)
    `CHK("wdt", `BSP_WDT_RST, wdt)
    `CHK("boost", `BSP_BOOST_RST, bst)
    `CHK("ready", 1'b1, ser_rdy)
    `CHK("sw", 1'b1, sw)
    $display("test power cycle done");
  endtask : test_power_cycle

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    test_reset();
    test_power_up();
    test_shipping();
    test_boost();
    test_watchdog();
    test_overload();
    test_power_cycle();
    complete_run();
  end
endmodule : tb_battery_switch_power_up
`undef CHK
`default_nettype wire
